// ---- rtl/card_spi_transaction_timing.sv ----
`timescale 1ns/10ps
`include "card_spi_params.svh"

// Summary of operation
// - A 6-byte command is answered by a 1- or 2-byte response after 1 to 8 idle byte times.
// - A command needing internal work is followed by busy bytes until the work is done.
// - A read data block starts at least one byte time after the previous response or block.
// - A stop command between read blocks gets a timely response and ends the block stream.
// - A stop command inside a read block abandons that block before the response.
// - A register read data block starts at least one byte time after its response.
// - Each written block gets a data response then busy; a stop token also brings busy.
// - Data-out is high whenever the card is selected and no response, data response, busy byte or token is being sent.
// - Data-out is released to high impedance while chip select is high.
// - Every byte on both data lines is shifted most significant bit first.
// - A data token is a start byte, 1 to 2048 user bytes and a 16-bit CRC.
// - Start bytes are FE for single writes and reads, FC for multi writes, FD for stop.
module card_spi_transaction_timing (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CS_B,
  input wire logic SCLK,
  input wire logic MOSI,
  output logic MISO,
  output logic MISO_OE,
  output logic CMD_VALID,
  output logic [47:0] CMD_FRAME,
  input wire logic RESP_LOAD,
  input wire logic [15:0] RESP_DATA,
  input wire logic RESP_TWO,
  input wire logic OP_BUSY,
  input wire logic RD_READY,
  input wire logic [7:0] RD_BYTE,
  input wire logic [11:0] BLOCK_LEN,
  output logic RD_TAKE,
  output logic BLOCK_DONE,
  input wire logic WR_ENABLE,
  output logic WR_VALID,
  output logic [7:0] WR_BYTE,
  input wire logic [7:0] WR_STATUS,
  output logic STOP_TOKEN
);

  logic cs_s1, cs_s2, sck_s1, sck_s2, sck_d, mosi_s1, mosi_s2;
  logic [2:0] bit_cnt;
  logic [6:0] rx_sh;
  logic [7:0] tx_sh;
  logic [39:0] cmd_sh;
  logic [11:0] idx;
  logic [3:0] gap;
  logic resp_ready;
  card_spi_pkg::response_s resp;
  card_spi_pkg::card_state_e state;

  wire sck_rise = sck_s2 & ~sck_d;
  wire sck_fall = ~sck_s2 & sck_d;
  wire rx_done = ~cs_s2 & sck_rise & (bit_cnt == 3'h7);
  // first bit of a byte is launched on the falling edge that opens it
  wire tx_load = ~cs_s2 & sck_fall & (bit_cnt == 3'h0);
  wire [7:0] rx_byte = {rx_sh, mosi_s2};
  wire cmd_start = (rx_byte[7:6] == `CMD_PREFIX);
  wire [11:0] block_last = BLOCK_LEN + `CRC_BYTES;
  wire is_start = (rx_byte == `START_BLOCK) | (rx_byte == `START_MULTI_WRITE);
  wire resp_last = ~(resp.two & (idx == 12'h000));
  wire resp_go = resp_ready | (gap == `RESP_GAP_MAX - 4'h1);
  wire sent_token = (state == card_spi_pkg::ST_RD_TX) & (idx != 12'h000);

  logic [7:0] next_tx;
  always_comb begin
    next_tx = `IDLE_BYTE;
    unique case (state)
      card_spi_pkg::ST_RESP_TX: begin
        next_tx = (resp.two & (idx == 12'h000)) ? resp.data[15:8] : resp.data[7:0];
      end
      card_spi_pkg::ST_BUSY: next_tx = `BUSY_BYTE;
      card_spi_pkg::ST_RD_TX: next_tx = (idx == 12'h000) ? `START_BLOCK : RD_BYTE;
      card_spi_pkg::ST_WR_RESP: next_tx = WR_STATUS;
      default: next_tx = `IDLE_BYTE;
    endcase
  end

  // pins cross from the host side: two stages before any use
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_d <= 1'b0;
      mosi_s1 <= 1'b1;
      mosi_s2 <= 1'b1;
    end else begin
      cs_s1 <= CS_B;
      cs_s2 <= cs_s1;
      sck_s1 <= SCLK;
      sck_s2 <= sck_s1;
      sck_d <= sck_s2;
      mosi_s1 <= MOSI;
      mosi_s2 <= mosi_s1;
    end
  end

  // bit framing restarts at every selection
  always_ff @(posedge CLK) begin
    if (!RST_B || cs_s2) begin
      bit_cnt <= 3'h0;
      rx_sh <= 7'h7F;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_sh <= {rx_sh[5:0], mosi_s2};
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      MISO_OE <= 1'b0;
    end else begin
      MISO_OE <= ~cs_s2;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B || cs_s2) begin
      tx_sh <= `IDLE_BYTE;
    end else if (tx_load) begin
      tx_sh <= next_tx;
    end else if (sck_fall) begin
      tx_sh <= {tx_sh[6:0], 1'b1};
    end
  end

  assign MISO = tx_sh[7];

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      RD_TAKE <= 1'b0;
    end else begin
      RD_TAKE <= tx_load & sent_token;
    end
  end

  // a load in the same cycle as the consume wins, so no answer is lost
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      resp_ready <= 1'b0;
      resp <= '0;
    end else if (RESP_LOAD) begin
      resp_ready <= 1'b1;
      resp <= '{two: RESP_TWO, data: RESP_DATA};
    end else if (rx_done && (cmd_start || (state == card_spi_pkg::ST_RESP_GAP && resp_go))) begin
      resp_ready <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state <= card_spi_pkg::ST_IDLE;
      idx <= 12'h000;
      gap <= 4'h0;
      cmd_sh <= '0;
      CMD_VALID <= 1'b0;
      CMD_FRAME <= '0;
      BLOCK_DONE <= 1'b0;
      WR_VALID <= 1'b0;
      WR_BYTE <= 8'h00;
      STOP_TOKEN <= 1'b0;
    end else begin
      CMD_VALID <= 1'b0;
      BLOCK_DONE <= 1'b0;
      WR_VALID <= 1'b0;
      STOP_TOKEN <= 1'b0;
      if (cs_s2) begin
        state <= card_spi_pkg::ST_IDLE;
      end else if (state == card_spi_pkg::ST_IDLE) begin
        state <= card_spi_pkg::ST_HOLD;
        gap <= 4'h0;
      end else if (rx_done) begin
        if (cmd_start && state != card_spi_pkg::ST_CMD_RX && state != card_spi_pkg::ST_WR_RX) begin
          // command ends a read block in flight; a write block in flight keeps receiving
          state <= card_spi_pkg::ST_CMD_RX;
          cmd_sh <= {32'h0000_0000, rx_byte};
          idx <= 12'h001;
        end else begin
          unique case (state)
            card_spi_pkg::ST_CMD_RX: begin
              cmd_sh <= {cmd_sh[31:0], rx_byte};
              idx <= idx + 12'h001;
              if (idx == `CMD_BYTES - 12'h001) begin
                CMD_VALID <= 1'b1;
                CMD_FRAME <= {cmd_sh, rx_byte};
                state <= card_spi_pkg::ST_RESP_GAP;
                gap <= 4'h0;
              end
            end
            card_spi_pkg::ST_RESP_GAP: begin
              gap <= gap + 4'h1;
              if (resp_go) begin
                state <= card_spi_pkg::ST_RESP_TX;
                idx <= 12'h000;
              end
            end
            card_spi_pkg::ST_RESP_TX: begin
              idx <= idx + 12'h001;
              if (resp_last) begin
                gap <= 4'h0;
                state <= OP_BUSY ? card_spi_pkg::ST_BUSY : card_spi_pkg::ST_HOLD;
              end
            end
            card_spi_pkg::ST_BUSY: begin
              if (!OP_BUSY) begin
                state <= card_spi_pkg::ST_HOLD;
                gap <= 4'h0;
              end
            end
            card_spi_pkg::ST_HOLD: begin
              // at least one idle byte before a block
              if (RD_READY) begin
                state <= card_spi_pkg::ST_RD_TX;
                idx <= 12'h000;
              end else if (WR_ENABLE && is_start) begin
                state <= card_spi_pkg::ST_WR_RX;
                idx <= 12'h000;
              end else if (WR_ENABLE && rx_byte == `STOP_TRAN) begin
                STOP_TOKEN <= 1'b1;
                state <= card_spi_pkg::ST_BUSY;
              end
            end
            card_spi_pkg::ST_RD_TX: begin
              idx <= idx + 12'h001;
              if (idx == block_last) begin
                BLOCK_DONE <= 1'b1;
                state <= card_spi_pkg::ST_HOLD;
                gap <= 4'h0;
              end
            end
            card_spi_pkg::ST_WR_RX: begin
              WR_VALID <= 1'b1;
              WR_BYTE <= rx_byte;
              idx <= idx + 12'h001;
              if (idx == block_last - 12'h001) begin
                BLOCK_DONE <= 1'b1;
                state <= card_spi_pkg::ST_WR_RESP;
              end
            end
            card_spi_pkg::ST_WR_RESP: state <= card_spi_pkg::ST_BUSY;
            default: state <= card_spi_pkg::ST_HOLD;
          endcase
        end
      end
    end
  end

endmodule

// ---- shared/card_spi_params.svh ----
`ifndef CARD_SPI_PARAMS_SVH
`define CARD_SPI_PARAMS_SVH

`define CLK_PERIOD_NS 100
`define IDLE_BYTE 8'hFF
`define BUSY_BYTE 8'h00
`define START_BLOCK 8'hFE
`define START_MULTI_WRITE 8'hFC
`define STOP_TRAN 8'hFD
`define CMD_BYTES 12'h006
`define CRC_BYTES 12'h002
`define RESP_GAP_MAX 4'h8
`define CMD_PREFIX 2'h1

`endif

// ---- shared/card_spi_pkg.sv ----
package card_spi_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_HOLD = 4'b0001,
    ST_CMD_RX = 4'b0010,
    ST_RESP_GAP = 4'b0011,
    ST_RESP_TX = 4'b0100,
    ST_BUSY = 4'b0101,
    ST_RD_TX = 4'b0110,
    ST_WR_RX = 4'b0111,
    ST_WR_RESP = 4'b1000
  } card_state_e;

  typedef struct packed {
    logic two;
    logic [15:0] data;
  } response_s;

endpackage

// ---- bench/card_spi_sva.sv ----
`timescale 1ns/10ps
module card_spi_sva (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CS_B,
  input wire logic MISO,
  input wire logic MISO_OE,
  input wire logic CMD_VALID,
  input wire logic [47:0] CMD_FRAME,
  input wire logic RD_TAKE,
  input wire logic WR_VALID,
  input wire logic STOP_TOKEN
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // select passes two sync stages, so allow a few cycles
  sequence off_long;
    CS_B[*6];
  endsequence
  sequence on_long;
    !CS_B[*6];
  endsequence
  a_oe_released: assert property (off_long |-> !MISO_OE)
    else $error("enable while deselected");
  a_oe_driving: assert property (on_long |-> MISO_OE)
    else $error("no enable while selected");
  a_frame_cause: assert property ($changed(CMD_FRAME) |-> ##[0:1] CMD_VALID)
    else $error("frame moved alone");
  a_gap_high: assert property ($rose(CMD_VALID) |-> MISO[*8])
    else $error("data out low in gap");
  a_cmd_pulse: assert property (CMD_VALID |=> !CMD_VALID[*8])
    else $error("command pulse long");
  a_take_space: assert property (RD_TAKE |=> !RD_TAKE[*8])
    else $error("read bytes too close");
  a_take_driving: assert property (RD_TAKE |-> !CS_B && MISO_OE)
    else $error("read byte while idle");
  a_wr_space: assert property (WR_VALID |=> !WR_VALID[*8])
    else $error("write bytes too close");
  a_stop_pulse: assert property (STOP_TOKEN |=> !STOP_TOKEN[*8])
    else $error("stop pulse long");
endmodule
bind card_spi_transaction_timing card_spi_sva i_card_spi_sva (.CLK, .RST_B, .CS_B, .MISO,
  .MISO_OE, .CMD_VALID, .CMD_FRAME, .RD_TAKE, .WR_VALID, .STOP_TOKEN);

// ---- bench/spi_host_model.sv ----
`timescale 1ns/10ps
module spi_host_model (
  input wire logic clk,
  input wire logic miso,
  output logic cs_b,
  output logic sclk,
  output logic mosi
);
  initial {cs_b, sclk, mosi} = 3'b100;
  task automatic half();
    repeat (4) @(posedge clk);
    #10;
  endtask
  // msb first, clock runs only in frames
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      half();
      sclk = 1'b1;
      half();
      rx[i] = miso;
      sclk = 1'b0;
    end
  endtask
  // select held over the whole transaction, deselected line shows the inverse level
  // a settle time either side keeps the select level long enough to be judged
  task automatic sel(input logic on);
    half();
    cs_b = !on;
    mosi = on;
    half();
  endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic RESP_LOAD = 1'b0;
  logic OP_BUSY = 1'b0;
  logic RD_READY = 1'b0;
  logic WR_ENABLE = 1'b0;
  logic resp_mute = 1'b0;
  logic resp_two = 1'b0;
  logic [15:0] resp_data = 16'h0000;
  logic [7:0] rd_byte = 8'h40;
  logic [11:0] block_len = 12'h002;
  int stops = 0;
  int blocks = 0;
  int gap_seen = 0;
  logic [7:0] wr_got = 8'h00;
  logic [7:0] rx;
  int miscompares = 0;
  int num_checks = 0;
  wire CS_B, SCLK, MOSI, MISO, MISO_OE, CMD_VALID, RD_TAKE, BLOCK_DONE, WR_VALID, STOP_TOKEN;
  wire [47:0] CMD_FRAME;
  wire [7:0] WR_BYTE;
  wire miso_w = MISO_OE ? MISO : 1'bz;
  card_spi_transaction_timing i_card_spi_transaction_timing (.CLK, .RST_B, .CS_B, .SCLK,
    .MOSI, .MISO, .MISO_OE, .CMD_VALID, .CMD_FRAME, .RESP_LOAD, .RESP_DATA(resp_data),
    .RESP_TWO(resp_two), .OP_BUSY, .RD_READY, .RD_BYTE(rd_byte), .BLOCK_LEN(block_len),
    .RD_TAKE,
    .BLOCK_DONE, .WR_ENABLE, .WR_VALID, .WR_BYTE, .WR_STATUS(8'hE5), .STOP_TOKEN);
  spi_host_model i_spi_host_model (.clk(CLK), .miso(miso_w), .cs_b(CS_B), .sclk(SCLK),
    .mosi(MOSI));
  initial forever #50 CLK = ~CLK;
  always @(posedge CLK) begin
    #10;
    // a muted core leaves the card to force its answer at the gap limit
    RESP_LOAD = (CMD_VALID === 1'b1) && !resp_mute;
    // core presents the next block byte once the card has taken one
    if (RD_TAKE === 1'b1) rd_byte = rd_byte + 8'h01;
    if (WR_VALID === 1'b1) wr_got = WR_BYTE;
    if (STOP_TOKEN === 1'b1) stops++;
    if (BLOCK_DONE === 1'b1) blocks++;
  end
  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic x(input logic [7:0] tx);
    i_spi_host_model.xfer(tx, rx);
  endtask
  task automatic cmd(input logic [47:0] c, input logic [7:0] r);
    for (int i = 5; i >= 0; i--) x(c[i*8+:8]);
    x(8'hFF);
    gap_seen = 0;
    while (rx === 8'hFF && gap_seen < 9) begin
      gap_seen++;
      x(8'hFF);
    end
    check("gap", 1, gap_seen >= 1 && gap_seen <= 8);
    check("resp", r, rx);
    check("frame", c, CMD_FRAME);
  endtask
  task automatic test_busy();
    i_spi_host_model.sel(1'b1);
    OP_BUSY = 1'b1;
    resp_data = 16'h0004;
    cmd(48'h4C0000000095, 8'h04);
    x(8'hFF);
    check("busy", 8'h00, rx);
    OP_BUSY = 1'b0;
    x(8'hFF);
    check("busy end", 8'h00, rx);
    x(8'hFF);
    check("idle", 8'hFF, rx);
    // idle bytes with data-in high before the next command
    resp_data = 16'h0102;
    resp_two = 1'b1;
    cmd(48'h4D0000000001, 8'h01);
    // clock kept running after the response
    x(8'hFF);
    check("resp low", 8'h02, rx);
    x(8'hFF);
    check("idle", 8'hFF, rx);
    resp_two = 1'b0;
    i_spi_host_model.sel(1'b0);
    $display("test_busy done");
  endtask
  task automatic test_read();
    int b;
    b = blocks;
    i_spi_host_model.sel(1'b1);
    RD_READY = 1'b1;
    resp_data = 16'h0000;
    cmd(48'h5200000000FF, 8'h00);
    x(8'hFF);
    check("access", 8'hFF, rx);
    x(8'hFF);
    check("start", 8'hFE, rx);
    for (int i = 0; i < 4; i++) begin
      x(8'hFF);
      check("data", 8'h40 + i, rx);
    end
    x(8'hFF);
    check("between", 8'hFF, rx);
    check("done", b + 1, blocks);
    x(8'hFF);
    check("start", 8'hFE, rx);
    x(8'hFF);
    check("data", 8'h44, rx);
    // stop lands inside the second block; the core stays silent, so the answer is forced
    RD_READY = 1'b0;
    resp_mute = 1'b1;
    cmd(48'h4C0000000061, 8'h00);
    check("late gap", 8, gap_seen);
    resp_mute = 1'b0;
    x(8'hFF);
    check("no block", 8'hFF, rx);
    check("abandon", b + 1, blocks);
    i_spi_host_model.sel(1'b0);
    $display("test_read done");
  endtask
  task automatic test_write();
    int b;
    int s;
    b = blocks;
    s = stops;
    i_spi_host_model.sel(1'b1);
    WR_ENABLE = 1'b1;
    cmd(48'h5900000000FF, 8'h00);
    x(8'hFF);
    x(8'hFC);
    for (int i = 0; i < 4; i++) begin
      x(8'h30 + 8'(i));
      check("wdata", 8'h30 + i, wr_got);
    end
    check("wdone", b + 1, blocks);
    x(8'hFF);
    check("wresp", 8'hE5, rx);
    x(8'hFF);
    check("wbusy", 8'h00, rx);
    x(8'hFF);
    check("widle", 8'hFF, rx);
    x(8'hFD);
    x(8'hFF);
    check("stop", s + 1, stops);
    check("sbusy", 8'h00, rx);
    i_spi_host_model.sel(1'b0);
    WR_ENABLE = 1'b0;
    $display("test_write done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    miscompares++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge CLK);
    #10;
    RST_B = 1'b1;
    test_busy();
    test_read();
    test_write();
    test_done();
  end
endmodule
